/* hdl/kms_scanner.sv */
// Key matrix scanner top: column drive, row sampling, registers, interrupt
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module kms_scanner
  import kms_pkg::*;
#(
  parameter int STEP_CYC = KMS_STEP_CYC,
  parameter int TW       = 8
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic [31:0]              reg_rdata,
  // Matrix pins
  input  wire logic [KMS_ROWS-1:0] key_row_input,
  output logic [KMS_COLS-1:0]      key_column_drive,
  output logic [KMS_COLS-1:0]      key_column_oe,
  output logic [KMS_ROWS-1:0]      key_row_pullup,
  output logic [KMS_COLS-1:0]      key_column_pullup,
  // Power control
  input  wire logic                sleep,
  input  wire logic                power_down,
  output logic                     wake_req,
  output logic                     reset_req,
  // Interrupt
  output logic                     irq
);

  // ==========================================================================
  // Pin synchroniser
  logic [KMS_ROWS-1:0] row_s1_reg;
  logic [KMS_ROWS-1:0] row_s2_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_s1_reg <= '1;
      row_s2_reg <= '1;
    end else if (ce) begin
      row_s1_reg <= key_row_input;
      row_s2_reg <= row_s1_reg;
    end
  end

  // ==========================================================================
  // Registers
  kms_bus_t        bus;
  logic [2:0]      ctrl_reg;
  logic [TW-1:0]   black_reg;
  logic [TW-1:0]   minp_reg;
  logic [1:0]      stat_reg;
  logic [1:0]      stat_next;
  logic [1:0]      ien_reg;
  logic [31:0]     rdata_reg;
  logic [31:0]     rdata_next;
  logic            wr_ctrl;
  logic            wr_black;
  logic            wr_minp;
  logic            wr_clr;
  logic            wr_ien;
  logic [1:0]      clr_mask;
  logic [1:0]      ev_set;
  logic            scan_en;
  logic [KMS_KEYS-1:0] key_state;
  logic [KMS_KEYS-1:0] key_press;
  logic [KMS_KEYS-1:0] key_rel;
  logic [95:0]     key_words;

  assign bus      = '{write: reg_write, read: reg_read, addr: reg_addr,
                      wdata: reg_wdata};
  assign wr_ctrl  = ce && bus.write && bus.addr == KMS_CTRL_OFS;
  assign wr_black = ce && bus.write && bus.addr == KMS_BLACK_OFS;
  assign wr_minp  = ce && bus.write && bus.addr == KMS_MINP_OFS;
  assign wr_clr   = ce && bus.write && bus.addr == KMS_CLR_OFS;
  assign wr_ien   = ce && bus.write && bus.addr == KMS_IEN_OFS;
  assign clr_mask = wr_clr ? bus.wdata[KMS_ST_W-1:0] : 2'h0;
  assign scan_en  = ctrl_reg[KMS_CTRL_EN];

  assign ev_set[KMS_ST_PRESS] = |key_press;
  assign ev_set[KMS_ST_REL]   = |key_rel;
  // New event wins over a clear in the same cycle
  assign stat_next = (stat_reg & ~clr_mask) | ev_set;
  assign key_words = {{(96 - KMS_KEYS){1'b0}}, key_state};

  always_comb begin
    rdata_next = 32'h0;
    case (bus.addr)
      KMS_CTRL_OFS:       rdata_next[2:0] = ctrl_reg;
      KMS_BLACK_OFS:      rdata_next[TW-1:0] = black_reg;
      KMS_MINP_OFS:       rdata_next[TW-1:0] = minp_reg;
      KMS_STAT_OFS:       rdata_next[1:0] = stat_reg;
      KMS_IEN_OFS:        rdata_next[1:0] = ien_reg;
      KMS_KEY0_OFS:       rdata_next = key_words[31:0];
      KMS_KEY0_OFS + 8'h04: rdata_next = key_words[63:32];
      KMS_KEY0_OFS + 8'h08: rdata_next = key_words[95:64];
      default:            rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg  <= KMS_CTRL_RST;
      black_reg <= TW'(KMS_BLACK_RST);
      minp_reg  <= TW'(KMS_MINP_RST);
      stat_reg  <= 2'h0;
      ien_reg   <= 2'h0;
      rdata_reg <= 32'h0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_reg <= bus.wdata[2:0];
      if (wr_black) black_reg <= bus.wdata[TW-1:0];
      if (wr_minp) minp_reg <= bus.wdata[TW-1:0];
      if (wr_ien) ien_reg <= bus.wdata[1:0];
      stat_reg  <= stat_next;
      rdata_reg <= bus.read ? rdata_next : 32'h0;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = |(stat_reg & ien_reg);

  // ==========================================================================
  // Scan sequencer
  kms_state_t     st_reg;
  kms_state_t     st_next;
  logic [31:0]    tmr_reg;
  logic [31:0]    tmr_next;
  logic [7:0]     set_reg;
  logic [7:0]     set_next;
  logic [3:0]     col_reg;
  logic [3:0]     col_next;
  logic [KMS_KEYS-1:0] snap_reg;
  logic           sample;
  logic           step_end;
  logic           last_col;
  logic           tick;

  assign last_col = col_reg == 4'(KMS_COLS - 1);
  assign step_end = tmr_reg >= 32'(STEP_CYC - 1);
  // Step timer runs free so sweeps start exactly every STEP_CYC
  assign tmr_next = step_end ? 32'h0 : tmr_reg + 32'h1;
  assign sample   = st_reg == KMS_SAMPLE;
  // One debounce tick per full sweep, one sweep per 2 ms step
  assign tick     = sample && last_col;

  always_comb begin
    st_next  = st_reg;
    col_next = col_reg;
    set_next = set_reg + 8'h1;
    case (st_reg)
      KMS_IDLE: begin
        set_next = 8'h0;
        if (scan_en && step_end) begin
          st_next  = KMS_SETTLE;
          col_next = 4'h0;
        end
      end
      KMS_SETTLE: begin
        if (set_reg >= 8'(KMS_SETTLE_CYC - 1)) begin
          st_next = KMS_SAMPLE;
        end
      end
      KMS_SAMPLE: begin
        // Every column gets the full settle time before its sample
        set_next = 8'h0;
        if (last_col) begin
          st_next = KMS_IDLE;
        end else begin
          st_next  = KMS_SETTLE;
          col_next = col_reg + 4'h1;
        end
      end
      default: st_next = KMS_IDLE;
    endcase
    if (!scan_en) begin
      st_next = KMS_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg   <= KMS_IDLE;
      tmr_reg  <= 32'h0;
      col_reg  <= 4'h0;
      set_reg  <= 8'h0;
      snap_reg <= '0;
    end else if (ce) begin
      st_reg  <= st_next;
      tmr_reg <= tmr_next;
      set_reg <= set_next;
      col_reg <= col_next;
      if (sample) begin
        // Low row with this column low means closed key
        for (int r = 0; r < KMS_ROWS; r++) begin
          snap_reg[r * KMS_COLS + int'(col_reg)] <= !row_s2_reg[r];
        end
      end
    end
  end

  // Open-drain columns: only the active one is driven low
  always_comb begin
    key_column_oe = '0;
    if (st_reg != KMS_IDLE) begin
      key_column_oe[col_reg] = 1'b1;
    end
  end
  assign key_column_drive  = '0;
  // Row pull-ups stay on so no external resistors are needed; a column's pull-up is off while that column is driven
  assign key_row_pullup    = '1;
  assign key_column_pullup = ~key_column_oe;

  // ==========================================================================
  // Debounce, one filter per key; every crossing is independent
  for (genvar k = 0; k < KMS_KEYS; k++) begin : g_key
    kms_debounce #(.TW(TW)) u_db (
      .clk        (clk),
      .rst        (rst),
      .ce         (ce),
      .tick       (tick),
      .raw        (k % KMS_COLS == KMS_COLS - 1 && sample ?
                   !row_s2_reg[k / KMS_COLS] : snap_reg[k]),
      .blackout   (black_reg),
      .min_press  (minp_reg),
      .state      (key_state[k]),
      .press      (key_press[k]),
      .release_ev (key_rel[k])
    );
  end

  // ==========================================================================
  // Sleep wake and power-down reset; combinational after the clocked row synchroniser, so the clock must run
  logic     any_row_low;
  kms_pwr_t pwr;

  assign any_row_low   = ~&row_s2_reg;
  assign pwr = '{
    wake_req:  ctrl_reg[KMS_CTRL_WAKE] && sleep && any_row_low,
    reset_req: ctrl_reg[KMS_CTRL_RSTEN] && power_down && any_row_low
  };
  assign wake_req      = pwr.wake_req;
  assign reset_req     = pwr.reset_req;

  // ==========================================================================
  // Checks
  one_col_a: assert property (@(posedge clk) disable iff (rst)
    $onehot0(key_column_oe))
    else $error("more than one column driven");
  irq_mask_a: assert property (@(posedge clk) disable iff (rst)
    ce && !wr_ien && |(ev_set & ien_reg) |=> irq)
    else $error("enabled event without interrupt");
  press_sticky_a: assert property (@(posedge clk) disable iff (rst)
    ce && ev_set[KMS_ST_PRESS] |=> stat_reg[KMS_ST_PRESS])
    else $error("press event lost");
  idle_cols_a: assert property (@(posedge clk) disable iff (rst)
    ce && !scan_en |=> key_column_oe == '0)
    else $error("column driven while disabled");
  wake_gate_a: assert property (@(posedge clk) disable iff (rst)
    wake_req |-> ctrl_reg[KMS_CTRL_WAKE] && sleep)
    else $error("wake without enable");
  rst_gate_a: assert property (@(posedge clk) disable iff (rst)
    reset_req |-> ctrl_reg[KMS_CTRL_RSTEN] && power_down)
    else $error("reset request unmasked");
  pullup_a: assert property (@(posedge clk) disable iff (rst)
    (key_column_pullup & key_column_oe) == '0)
    else $error("pulled and driven together");
  rdata_one_a: assert property (@(posedge clk) disable iff (rst)
    ce && !reg_read |=> reg_rdata == 32'h0)
    else $error("read data outside slot");

endmodule : kms_scanner
`default_nettype wire

/* hdl/kms_pkg.sv */
// Package of constants and types for the key matrix scanner
package kms_pkg;

  // ==========================================================================
  // Matrix geometry
  localparam int KMS_ROWS      = 8;
  localparam int KMS_COLS      = 11;
  localparam int KMS_KEYS      = KMS_ROWS * KMS_COLS;
  localparam int KMS_MAX_KEYS  = 88;

  // ==========================================================================
  // Timing
  localparam int KMS_CLK_MHZ   = 250;
  localparam int KMS_STEP_US   = 2000;
  localparam int KMS_STEP_CYC  = KMS_STEP_US * KMS_CLK_MHZ;
  localparam int KMS_SETTLE_NS = 1000;
  localparam int KMS_CLK_NS    = 4;
  localparam int KMS_SETTLE_CYC = (KMS_SETTLE_NS + KMS_CLK_NS - 1) / KMS_CLK_NS;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] KMS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] KMS_BLACK_OFS  = 8'h04;
  localparam logic [7:0] KMS_MINP_OFS   = 8'h08;
  localparam logic [7:0] KMS_STAT_OFS   = 8'h0C;
  localparam logic [7:0] KMS_CLR_OFS    = 8'h10;
  localparam logic [7:0] KMS_IEN_OFS    = 8'h14;
  localparam logic [7:0] KMS_KEY0_OFS   = 8'h20;
  localparam int         KMS_KEY_WORDS  = 3;

  // Control fields
  localparam int KMS_CTRL_EN    = 0;
  localparam int KMS_CTRL_WAKE  = 1;
  localparam int KMS_CTRL_RSTEN = 2;
  // Status fields
  localparam int KMS_ST_PRESS   = 0;
  localparam int KMS_ST_REL     = 1;
  localparam int KMS_ST_W       = 2;

  // Reset values
  localparam logic [2:0] KMS_CTRL_RST  = 3'h0;
  localparam logic [7:0] KMS_BLACK_RST = 8'h01;
  localparam logic [7:0] KMS_MINP_RST  = 8'h02;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    KMS_IDLE   = 2'b00,
    KMS_SETTLE = 2'b01,
    KMS_SAMPLE = 2'b10
  } kms_state_t;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } kms_bus_t;

  typedef struct packed {
    logic wake_req;
    logic reset_req;
  } kms_pwr_t;

endpackage : kms_pkg

/* hdl/kms_debounce.sv */
// Per-key debounce filter with blackout and minimum press time
`timescale 1ns/1ps
`default_nettype none
module kms_debounce
  import kms_pkg::*;
#(
  parameter int TW = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  // Scan sample
  input  wire logic          tick,
  input  wire logic          raw,
  input  wire logic [TW-1:0] blackout,
  input  wire logic [TW-1:0] min_press,
  // Result
  output logic               state,
  output logic               press,
  output logic               release_ev
);

  // ==========================================================================
  // Filter
  logic [TW-1:0] cnt_reg;
  logic [TW-1:0] cnt_next;
  logic          state_reg;
  logic [TW-1:0] need;
  logic          differs;
  logic          done;

  // Press waits the longer of both thresholds; release only the blackout
  assign need     = (!state_reg && min_press > blackout) ? min_press : blackout;
  assign differs  = raw != state_reg;
  assign done     = differs && (cnt_reg + TW'(1) >= need);
  assign cnt_next = (!differs || done) ? '0 : cnt_reg + TW'(1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= '0;
      state_reg <= 1'b0;
    end else if (ce && tick) begin
      cnt_reg <= cnt_next;
      if (done) begin
        state_reg <= raw;
      end
    end
  end

  assign state      = state_reg;
  assign press      = ce && tick && done && raw;
  assign release_ev = ce && tick && done && !raw;

endmodule : kms_debounce
`default_nettype wire

/* test/kms_matrix_model.sv */
// Passive switch matrix model facing the key matrix scanner
`timescale 1ns/1ps
`default_nettype none
module kms_matrix_model
  import kms_pkg::*;
(
  // Column side
  input  wire logic [KMS_COLS-1:0] key_column_drive,
  input  wire logic [KMS_COLS-1:0] key_column_oe,
  // Key closures, index row*11+col
  input  wire logic [KMS_KEYS-1:0] pressed,
  // Row side
  output logic      [KMS_ROWS-1:0] key_row_input
);
  // ==========================================================================
  // Wired-AND rows
  always_comb begin
    for (int r = 0; r < KMS_ROWS; r++) begin
      key_row_input[r] = 1'b1; // Pull-up wins on an open row
      for (int c = 0; c < KMS_COLS; c++) begin
        if (pressed[r*KMS_COLS+c] && key_column_oe[c] && !key_column_drive[c])
          key_row_input[r] = 1'b0; // Closed crossing shorts row low
      end
    end
  end
endmodule : kms_matrix_model
`default_nettype wire

/* test/test_kms_scanner.sv */
// Self-checking bench for the key matrix scanner
`timescale 1ns/1ps
`default_nettype none
module test_kms_scanner;
  import kms_pkg::*;
  // Short sweep keeps the run small; must exceed 11*251
  localparam int STEP = 3000;
  // ==========================================================================
  // Signals
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic [7:0]          reg_addr = 8'h00;
  logic [31:0]         reg_wdata = 32'h0;
  logic                reg_write = 1'b0;
  logic                reg_read = 1'b0;
  logic [31:0]         reg_rdata;
  logic [KMS_ROWS-1:0] key_row_input;
  logic [KMS_COLS-1:0] key_column_drive;
  logic [KMS_COLS-1:0] key_column_oe;
  logic [KMS_ROWS-1:0] key_row_pullup;
  logic [KMS_COLS-1:0] key_column_pullup;
  logic                sleep = 1'b0;
  logic                power_down = 1'b0;
  logic                wake_req;
  logic                reset_req;
  logic                irq;
  logic [KMS_KEYS-1:0] pressed = '0;
  int                  mismatches = 0;
  int                  samples_checked = 0;

  always #2 clk = ~clk;

  kms_scanner #(.STEP_CYC(STEP), .TW(8)) kms_scanner_inst (
    .clk(clk), .rst(rst), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .key_row_input(key_row_input), .key_column_drive(key_column_drive),
    .key_column_oe(key_column_oe), .key_row_pullup(key_row_pullup),
    .key_column_pullup(key_column_pullup), .sleep(sleep),
    .power_down(power_down), .wake_req(wake_req), .reset_req(reset_req),
    .irq(irq)
  );
  kms_matrix_model kms_matrix_model_inst (
    .key_column_drive(key_column_drive), .key_column_oe(key_column_oe),
    .pressed(pressed), .key_row_input(key_row_input)
  );

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Poll status until bit b sets; bounded to eight sweeps
  task automatic wait_bit(input int b, output logic [31:0] d);
    for (int i = 0; i < 4*STEP; i++) begin
      rd(KMS_STAT_OFS, d);
      if (d[b] === 1'b1) break;
    end
  endtask : wait_bit

  task automatic chk_keys();
    logic [95:0] exp;
    logic [31:0] d;
    exp = {8'h00, pressed};
    for (int w = 0; w < KMS_KEY_WORDS; w++) begin
      rd(8'(KMS_KEY0_OFS + 8'(4*w)), d);
      chk(d, exp[w*32 +: 32]);
    end
  endtask : chk_keys

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Waits for a column pattern, then one more edge to drive on
  task automatic wait_oe(input logic [10:0] v);
    do begin
      @(posedge clk);
      #1;
    end while (key_column_oe !== v);
    @(posedge clk);
  endtask : wait_oe

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    rd(KMS_CTRL_OFS, d);  chk(d, 32'h0);
    rd(KMS_BLACK_OFS, d); chk(d, 32'h1);
    rd(KMS_MINP_OFS, d);  chk(d, 32'h2);
    rd(KMS_STAT_OFS, d);  chk(d, 32'h0);
    rd(KMS_IEN_OFS, d);   chk(d, 32'h0);
    rd(KMS_CLR_OFS, d);   chk(d, 32'h0);
    rd(8'hFC, d);         chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'(key_column_oe), 32'h0);
  endtask : t_reset

  task automatic t_scan();
    logic [10:0] last;
    int          n;
    last = '0;
    n = 0;
    wr(KMS_CTRL_OFS, 32'h1);
    repeat (3*STEP) begin
      @(posedge clk);
      #1;
      chk(32'($onehot0(key_column_oe)), 32'h1);
      chk(32'(key_column_pullup ^ key_column_oe), 32'h7FF);
      chk(32'(key_column_drive & key_column_oe), 32'h0);
      chk(32'(key_row_pullup), 32'hFF);
      if (key_column_oe != 0 && key_column_oe !== last) begin
        if (last != 0)
          chk(32'(key_column_oe), (last == 11'h400) ? 32'h1 : 32'(last) << 1);
        last = key_column_oe;
        n++;
      end
    end
    chk(32'(n >= 22), 32'h1);
  endtask : t_scan

  task automatic t_press();
    logic [31:0] d;
    // Change keys between sweeps so both land on the same tick
    wait_oe(11'h000);
    pressed[25] <= 1'b1;
    pressed[87] <= 1'b1;
    wait_bit(KMS_ST_PRESS, d);
    chk(d & 32'h1, 32'h1);
    chk(32'(irq), 32'h0);
    chk_keys();
    wr(KMS_IEN_OFS, 32'h1);
    settle(2);
    chk(32'(irq), 32'h1);
    wr(KMS_CLR_OFS, 32'h1);
    settle(2);
    chk(32'(irq), 32'h0);
  endtask : t_press

  task automatic t_release();
    logic [31:0] d;
    wr(KMS_IEN_OFS, 32'h2);
    wait_oe(11'h000);
    pressed <= '0;
    wait_bit(KMS_ST_REL, d);
    chk(d & 32'h2, 32'h2);
    settle(2);
    chk(32'(irq), 32'h1);
    chk_keys();
    wr(KMS_CLR_OFS, 32'h3);
    settle(2);
    chk(32'(irq), 32'h0);
  endtask : t_release

  task automatic t_glitch();
    logic [31:0] d;
    // Start of column 7: the bounce spans exactly one sample
    wait_oe(11'h040);
    wait_oe(11'h080);
    pressed[40] <= 1'b1;
    repeat (300) @(posedge clk);
    pressed[40] <= 1'b0;
    settle(4*STEP);
    rd(KMS_STAT_OFS, d);
    chk(d, 32'h0);
    chk_keys();
  endtask : t_glitch

  task automatic t_thresh();
    logic [31:0] d;
    wr(KMS_MINP_OFS, 32'h4);
    rd(KMS_MINP_OFS, d);
    chk(d, 32'h4);
    @(posedge clk);
    pressed[0] <= 1'b1;
    settle(2*STEP);
    rd(KMS_STAT_OFS, d);
    chk(d, 32'h0);
    wait_bit(KMS_ST_PRESS, d);
    chk(d & 32'h1, 32'h1);
    wr(KMS_MINP_OFS, 32'h2);
    wr(KMS_CLR_OFS, 32'h3);
  endtask : t_thresh

  // Watch both power requests over one sweep and more
  task automatic watch(input logic [31:0] ctrl, output logic w, output logic r);
    w = 1'b0;
    r = 1'b0;
    wr(KMS_CTRL_OFS, ctrl);
    repeat (STEP + 100) begin
      @(posedge clk);
      #1;
      w = w | (wake_req === 1'b1);
      r = r | (reset_req === 1'b1);
    end
  endtask : watch

  task automatic t_power();
    logic w;
    logic r;
    @(posedge clk);
    sleep <= 1'b1;
    watch(32'h1, w, r); chk(32'(w), 32'h0);
    watch(32'h3, w, r); chk(32'(w), 32'h1);
    @(posedge clk);
    sleep      <= 1'b0;
    power_down <= 1'b1;
    watch(32'h1, w, r); chk(32'(r), 32'h0);
    watch(32'h5, w, r); chk(32'(r), 32'h1);
  endtask : t_power

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_scan();
    t_press();
    t_release();
    t_glitch();
    t_thresh();
    t_power();
    close_out();
  end

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule : test_kms_scanner
`default_nettype wire
